// ==== core/line_unit_cfg_defs.vh ====
`ifndef LINE_UNIT_CFG_DEFS_VH
`define LINE_UNIT_CFG_DEFS_VH

// Global register offsets
`define OFS_SILICON_REVISION 8'h00
`define OFS_SOFT_RESET_TRIGGER 8'h01
`define OFS_GLOBAL_SETUP 8'h20
`define OFS_IRQ_SOURCE_CHANNEL 8'h21
// Local register offsets, channel one
`define OFS_LINE_IMPEDANCE_SELECT 8'h02
`define OFS_JITTER_ATTENUATOR_SETUP 8'h03
`define OFS_TRANSMIT_PATH_SETUP 8'h04
// Distance from channel one to channel two
`define OFS_CHANNEL_STRIDE 8'h20

// Global setup fields
`define GS_MONITOR_HI 7
`define GS_MONITOR_LO 6
`define GS_BROADCAST 3
`define GS_IRQ_DISABLE 2
`define GS_IRQ_STYLE_HI 1
`define GS_IRQ_STYLE_LO 0
`define GS_WRITE_MASK 8'hcf
`define GS_RESET_VAL 8'h04

// Line impedance fields
`define IMP_TX_HI 5
`define IMP_TX_LO 3
`define IMP_RX_HI 2
`define IMP_RX_LO 0
`define IMP_WRITE_MASK 8'h3f
`define IMP_RESET_VAL 8'h00

// Jitter attenuator fields
`define ATTENUATOR_LIMIT_MODE_BIT 5
`define JA_PLACE_HI 4
`define JA_PLACE_LO 3
`define JA_DEPTH_HI 2
`define JA_DEPTH_LO 1
`define JA_BW_BIT 0
`define JA_WRITE_MASK 8'h3f
`define JA_RESET_VAL 8'h20

// Transmit path fields
`define TX_POWER_DOWN_BIT 4
`define TX_POLARITY_BIT 3
`define TX_EDGE_BIT 2
`define TX_MODE_HI 1
`define TX_MODE_LO 0
`define TX_WRITE_MASK 8'h1f
`define TX_RESET_VAL 8'h00

// Soft reset timing
`define CLK_PERIOD_NS 4
`define SOFT_RESET_LIMIT_NS 1000
`define SOFT_RESET_LIMIT_CYC (`SOFT_RESET_LIMIT_NS / `CLK_PERIOD_NS)
`define SOFT_RESET_HOLD_CYC 8'h04

`endif

// ==== core/line_unit_cfg_regs.v ====
`timescale 1ns/10ps
`default_nettype none
`include "line_unit_cfg_defs.vh"

module line_unit_cfg_regs #(
	parameter [7:0] SILICON_REV = 8'ha5, // Arbitrary revision value
	parameter CHANNELS = 2
)(
	input wire core_clk,
	input wire sys_rst,
	input wire cs_n,
	input wire wr_n,
	input wire rd_n,
	input wire [7:0] addr,
	input wire [7:0] d_in,
	output reg [7:0] d_out,
	output reg d_oe,
	input wire [1:0] chan_irq_pending,
	output reg irq_out,
	output reg irq_oe,
	output reg mon_rx_path,
	output reg mon_tx_path,
	output reg [3:0] tx_term_sel,
	output reg [3:0] rx_term_sel,
	output reg [1:0] attenuator_limit_mode,
	output reg [1:0] ja_in_tx,
	output reg [1:0] ja_in_rx,
	output reg [3:0] ja_depth_sel,
	output reg [1:0] ja_bw_low,
	output reg [1:0] tx_powered_down,
	output reg [1:0] tx_driver_hiz,
	output reg [1:0] tx_data_invert,
	output reg [1:0] tx_sample_rising,
	output reg [1:0] tx_hdb3_en,
	output reg [1:0] tx_ami_en,
	output reg [1:0] tx_dual_rail
);

	// Termination code to 0:75 ohm, 1:120 ohm, 2:external, 3:reserved
	function [1:0] term_decode;
		input [2:0] code;
		begin
			if (code[2])
				term_decode = 2'h2;
			else if (code[1])
				term_decode = 2'h3;
			else
				term_decode = {1'b0, code[0]};
		end
	endfunction

	// Local decode: {valid, channel, register index}
	function [3:0] local_decode;
		input [7:0] a;
		reg [7:0] base;
		begin
			base = {3'h0, a[4:0]};
			local_decode = 4'h0;
			if (a[7:6] == 2'h0 && base >= `OFS_LINE_IMPEDANCE_SELECT
				&& base <= `OFS_TRANSMIT_PATH_SETUP)
			begin
				local_decode = {1'b1, a[5], base[1:0]};
			end
		end
	endfunction

	// Pin synchronisers, three stages each
	reg [2:0] cs_sy_q;
	reg [2:0] wr_sy_q;
	reg [2:0] rd_sy_q;
	// Filtered strobe levels, active low
	reg cs_st_n_q;
	reg wr_st_n_q;
	reg rd_st_n_q;
	reg wr_act_q; // Previous write-active level
	// Address and data pins, three stages each
	reg [7:0] addr_s1_q; // First stage, may be metastable
	reg [7:0] addr_s2_q; // Second stage
	reg [7:0] addr_s3_q; // Third stage
	reg [7:0] addr_q; // Accepted address
	reg [7:0] din_s1_q; // First stage, may be metastable
	reg [7:0] din_s2_q; // Second stage
	reg [7:0] din_s3_q; // Third stage
	reg [7:0] din_q; // Accepted write data

	// Global and per-channel storage
	reg [7:0] gs_q;
	reg [7:0] imp_q [0:1];
	reg [7:0] ja_q [0:1];
	reg [7:0] tx_q [0:1];
	reg [1:0] drv_hold_q; // Driver held floating since reset
	reg [7:0] srst_cnt_q; // Soft reset hold counter
	integer i;

	wire wr_act;
	wire rd_act;
	wire wr_take;
	wire srst_busy;
	wire rst_any;
	wire [3:0] lsel;
	wire irq_req;

	assign wr_act = ~cs_st_n_q & ~wr_st_n_q;
	assign rd_act = ~cs_st_n_q & ~rd_st_n_q;
	assign wr_take = wr_act & ~wr_act_q;
	assign srst_busy = (srst_cnt_q != 8'h00);
	assign rst_any = sys_rst | srst_busy;
	assign lsel = local_decode(addr_q);

	// Shift strobes through three flops, accept when stages two and three agree
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			cs_sy_q <= 3'h7;
			wr_sy_q <= 3'h7;
			rd_sy_q <= 3'h7;
			cs_st_n_q <= 1'b1;
			wr_st_n_q <= 1'b1;
			rd_st_n_q <= 1'b1;
			wr_act_q <= 1'b0;
		end
		else
		begin
			cs_sy_q <= {cs_sy_q[1:0], cs_n};
			wr_sy_q <= {wr_sy_q[1:0], wr_n};
			rd_sy_q <= {rd_sy_q[1:0], rd_n};
			if (cs_sy_q[1] == cs_sy_q[2])
				cs_st_n_q <= cs_sy_q[2];
			if (wr_sy_q[1] == wr_sy_q[2])
				wr_st_n_q <= wr_sy_q[2];
			if (rd_sy_q[1] == rd_sy_q[2])
				rd_st_n_q <= rd_sy_q[2];
			wr_act_q <= wr_act;
		end
	end

	// Address and data pins pass three flops like the strobes; a value
	// is accepted once stages two and three agree, on the same edge as
	// the filtered strobe level, so a write never sees a half-moved bus
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			addr_s1_q <= 8'h00;
			addr_s2_q <= 8'h00;
			addr_s3_q <= 8'h00;
			addr_q <= 8'h00;
			din_s1_q <= 8'h00;
			din_s2_q <= 8'h00;
			din_s3_q <= 8'h00;
			din_q <= 8'h00;
		end
		else
		begin
			addr_s1_q <= addr;
			addr_s2_q <= addr_s1_q;
			addr_s3_q <= addr_s2_q;
			din_s1_q <= d_in;
			din_s2_q <= din_s1_q;
			din_s3_q <= din_s2_q;
			// Bus settled over two samples
			if (addr_s2_q == addr_s3_q)
				addr_q <= addr_s3_q;
			if (din_s2_q == din_s3_q)
				din_q <= din_s3_q;
		end
	end

	// Soft reset: a write only starts the hold, nothing is stored
	always @(posedge core_clk)
	begin
		if (sys_rst)
			srst_cnt_q <= 8'h00;
		else if (wr_take && addr_q == `OFS_SOFT_RESET_TRIGGER)
			srst_cnt_q <= `SOFT_RESET_HOLD_CYC;
		else if (srst_busy)
			srst_cnt_q <= srst_cnt_q - 8'h01;
	end

	// Register writes, with broadcast copy to the other channel
	always @(posedge core_clk)
	begin
		if (rst_any)
		begin
			gs_q <= `GS_RESET_VAL;
			for (i = 0; i < CHANNELS; i = i + 1)
			begin
				imp_q[i] <= `IMP_RESET_VAL;
				ja_q[i] <= `JA_RESET_VAL;
				tx_q[i] <= `TX_RESET_VAL;
			end
			drv_hold_q <= 2'h3;
		end
		else if (wr_take)
		begin
			// Reserved bits are stored as zero
			if (addr_q == `OFS_GLOBAL_SETUP)
				gs_q <= din_q & `GS_WRITE_MASK;
			for (i = 0; i < CHANNELS; i = i + 1)
			begin
				// Addressed channel, or every channel in broadcast
				if (lsel[3] && (lsel[2] == i[0] ||
					gs_q[`GS_BROADCAST]))
				begin
					case (lsel[1:0])
						2'h2:
							imp_q[i] <= din_q & `IMP_WRITE_MASK;
						2'h3:
							ja_q[i] <= din_q & `JA_WRITE_MASK;
						2'h0:
						begin
							tx_q[i] <= din_q & `TX_WRITE_MASK;
							drv_hold_q[i] <= 1'b0;
						end
						default:
							imp_q[i] <= imp_q[i];
					endcase
				end
			end
		end
	end

	// Host read port: data driven while a read is stable
	always @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			d_out <= 8'h00;
			d_oe <= 1'b0;
		end
		else
		begin
			d_oe <= rd_act;
			if (lsel[3])
			begin
				case (lsel[1:0])
					2'h2:
						d_out <= imp_q[lsel[2]];
					2'h3:
						d_out <= ja_q[lsel[2]];
					default:
						d_out <= tx_q[lsel[2]];
				endcase
			end
			else if (addr_q == `OFS_SILICON_REVISION)
				d_out <= SILICON_REV;
			else if (addr_q == `OFS_GLOBAL_SETUP)
				d_out <= gs_q;
			else if (addr_q == `OFS_IRQ_SOURCE_CHANNEL)
				d_out <= {6'h00, ~chan_irq_pending};
			else
				d_out <= 8'h00; // Unmapped and soft reset read zero
		end
	end

	// Interrupt request, gated by the global disable
	assign irq_req = ~gs_q[`GS_IRQ_DISABLE] & (|chan_irq_pending);

	// Interrupt pin style and global monitor outputs
	always @(posedge core_clk)
	begin
		if (rst_any)
		begin
			irq_out <= 1'b0;
			irq_oe <= 1'b0;
			mon_rx_path <= 1'b0;
			mon_tx_path <= 1'b0;
		end
		else
		begin
			if (!gs_q[`GS_IRQ_STYLE_LO])
			begin
				// Open drain, pulls low only when asserted
				irq_out <= 1'b0;
				irq_oe <= irq_req;
			end
			else
			begin
				// Push-pull, high bit picks active high
				irq_out <= gs_q[`GS_IRQ_STYLE_HI] ? irq_req : ~irq_req;
				irq_oe <= 1'b1;
			end
			mon_rx_path <= gs_q[`GS_MONITOR_LO] & ~gs_q[`GS_MONITOR_HI];
			mon_tx_path <= gs_q[`GS_MONITOR_LO] & gs_q[`GS_MONITOR_HI];
		end
	end

	// Per-channel decoded settings
	wire [3:0] tx_term_d;
	wire [3:0] rx_term_d;
	wire [3:0] ja_depth_d;
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g = g + 1)
		begin : chan_dec
			assign tx_term_d[2*g+:2] =
				term_decode(imp_q[g][`IMP_TX_HI:`IMP_TX_LO]);
			assign rx_term_d[2*g+:2] =
				term_decode(imp_q[g][`IMP_RX_HI:`IMP_RX_LO]);
			// 0:128 bits, 1:64 bits, 2:32 bits
			assign ja_depth_d[2*g+:2] = ja_q[g][`JA_DEPTH_HI] ? 2'h2 :
				{1'b0, ja_q[g][`JA_DEPTH_LO]};
		end
	endgenerate

	// Per-channel output flops
	always @(posedge core_clk)
	begin
		if (rst_any)
		begin
			tx_term_sel <= 4'h0;
			rx_term_sel <= 4'h0;
			attenuator_limit_mode <= 2'h3;
			ja_in_tx <= 2'h0;
			ja_in_rx <= 2'h0;
			ja_depth_sel <= 4'h0;
			ja_bw_low <= 2'h0;
			tx_powered_down <= 2'h0;
			tx_driver_hiz <= 2'h3;
			tx_data_invert <= 2'h0;
			tx_sample_rising <= 2'h0;
			tx_hdb3_en <= 2'h3; // Default mode 00 is HDB3
			tx_ami_en <= 2'h0;
			tx_dual_rail <= 2'h0;
		end
		else
		begin
			tx_term_sel <= tx_term_d;
			rx_term_sel <= rx_term_d;
			ja_depth_sel <= ja_depth_d;
			for (i = 0; i < CHANNELS; i = i + 1)
			begin
				attenuator_limit_mode[i] <= ja_q[i][`ATTENUATOR_LIMIT_MODE_BIT];
				ja_in_tx[i] <= ja_q[i][`JA_PLACE_LO] &
					~ja_q[i][`JA_PLACE_HI];
				ja_in_rx[i] <= ja_q[i][`JA_PLACE_LO] &
					ja_q[i][`JA_PLACE_HI];
				ja_bw_low[i] <= ja_q[i][`JA_BW_BIT];
				tx_powered_down[i] <= tx_q[i][`TX_POWER_DOWN_BIT];
				tx_driver_hiz[i] <= drv_hold_q[i] |
					tx_q[i][`TX_POWER_DOWN_BIT];
				tx_data_invert[i] <= tx_q[i][`TX_POLARITY_BIT];
				tx_sample_rising[i] <= tx_q[i][`TX_EDGE_BIT];
				tx_hdb3_en[i] <= (tx_q[i][`TX_MODE_HI:`TX_MODE_LO]
					== 2'h0);
				tx_ami_en[i] <= (tx_q[i][`TX_MODE_HI:`TX_MODE_LO]
					== 2'h1);
				tx_dual_rail[i] <= tx_q[i][`TX_MODE_HI];
			end
		end
	end

endmodule // line_unit_cfg_regs
`default_nettype wire

// ==== test/host_bus_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module host_bus_model (
	input wire logic core_clk,
	output var logic cs_n,
	output var logic wr_n,
	output var logic rd_n,
	output var logic [7:0] addr,
	output var logic [7:0] d_in,
	input wire logic [7:0] d_out,
	input wire logic d_oe
);
	// Idle pins at time zero
	initial
	begin
		{cs_n, wr_n, rd_n} = 3'b111;
		addr = 8'h00;
		d_in = 8'h00;
	end
	// Write: strobes low 8 clocks, then idle 8 clocks
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		d_in <= d;
		{cs_n, wr_n} <= 2'b00;
		repeat (8) @(posedge core_clk);
		{cs_n, wr_n} <= 2'b11;
		d_in <= ~d; // Released data shows the inverse
		repeat (8) @(posedge core_clk);
	endtask
	// Read: bounded wait for the drive enable
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		int n;
		@(posedge core_clk);
		addr <= a;
		{cs_n, rd_n} <= 2'b00;
		for (n = 0; n < 16 && d_oe !== 1'b1; n++)
			@(posedge core_clk);
		if (n == 16)
		begin
			tb.num_errors++;
			tb.summarize();
		end
		d = d_out;
		{cs_n, rd_n} <= 2'b11;
		repeat (8) @(posedge core_clk);
	endtask
endmodule // host_bus_model
`default_nettype wire

// ==== test/line_unit_cfg_regs_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module line_unit_cfg_props #(
	parameter [7:0] SILICON_REV = 8'ha5 // Arbitrary revision value
)(
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] d_out,
	input wire logic d_oe,
	input wire logic [1:0] chan_irq_pending,
	input wire logic irq_out,
	input wire logic irq_oe,
	input wire logic mon_rx_path,
	input wire logic mon_tx_path,
	input wire logic [1:0] attenuator_limit_mode,
	input wire logic [1:0] ja_in_tx,
	input wire logic [1:0] ja_in_rx,
	input wire logic [1:0] tx_powered_down,
	input wire logic [1:0] tx_driver_hiz,
	input wire logic [1:0] tx_hdb3_en,
	input wire logic [1:0] tx_ami_en,
	input wire logic [1:0] tx_dual_rail
);
	localparam int RST_LIMIT = 250; // One microsecond in clocks
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// Soft reset slot written long enough to be taken
	sequence s_rst_wr;
		(!cs_n && !wr_n && addr == 8'h01)[*6];
	endsequence
	// Read strobe held past the synchroniser
	sequence s_rd;
		(!cs_n && !rd_n)[*7];
	endsequence
	a_read_answer: assert property (s_rd |-> d_oe)
		else $error("read strobe not answered");
	a_rev_value: assert property ((d_oe && addr == 8'h00)[*3] |->
		d_out == SILICON_REV) else $error("revision read wrong");
	a_trigger_empty: assert property ((d_oe && addr == 8'h01)[*3] |->
		d_out == 8'h00) else $error("reset slot read not zero");
	a_chan_flags: assert property ((d_oe && addr == 8'h21 &&
		$stable(chan_irq_pending))[*3] |->
		d_out == {6'h00, ~chan_irq_pending}) else $error("flags wrong");
	a_soft_reset: assert property (s_rst_wr |-> ##[0:RST_LIMIT]
		(attenuator_limit_mode == 2'b11 && tx_driver_hiz == 2'b11))
		else $error("soft reset late");
	a_power_hiz: assert property (!(|(tx_powered_down & ~tx_driver_hiz)))
		else $error("powered down driver not floating");
	a_mode_onehot: assert property ($onehot({tx_hdb3_en[0], tx_ami_en[0],
		tx_dual_rail[0]}) && $onehot({tx_hdb3_en[1], tx_ami_en[1],
		tx_dual_rail[1]})) else $error("coding mode not one-hot");
	a_mon_excl: assert property (!(mon_rx_path && mon_tx_path))
		else $error("both monitor paths on");
	a_ja_place: assert property (!(|(ja_in_tx & ja_in_rx)))
		else $error("attenuator in both paths");
	a_irq_level: assert property (irq_out |-> irq_oe)
		else $error("interrupt high while undriven");
endmodule // line_unit_cfg_props
bind line_unit_cfg_regs line_unit_cfg_props
	#(.SILICON_REV(SILICON_REV)) line_unit_cfg_props_i (
	.core_clk(core_clk), .sys_rst(sys_rst), .cs_n(cs_n),
	.wr_n(wr_n), .rd_n(rd_n), .addr(addr), .d_out(d_out),
	.d_oe(d_oe), .chan_irq_pending(chan_irq_pending),
	.irq_out(irq_out), .irq_oe(irq_oe), .mon_rx_path(mon_rx_path),
	.mon_tx_path(mon_tx_path), .attenuator_limit_mode(attenuator_limit_mode),
	.ja_in_tx(ja_in_tx), .ja_in_rx(ja_in_rx),
	.tx_powered_down(tx_powered_down), .tx_driver_hiz(tx_driver_hiz),
	.tx_hdb3_en(tx_hdb3_en), .tx_ami_en(tx_ami_en),
	.tx_dual_rail(tx_dual_rail));
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [1:0] chan_irq_pending = 2'b00;
	logic cs_n, wr_n, rd_n, d_oe, irq_out, irq_oe, mon_rx_path, mon_tx_path;
	logic [7:0] addr, d_in, d_out;
	logic [3:0] tx_term_sel, rx_term_sel, ja_depth_sel;
	logic [1:0] attenuator_limit_mode, ja_in_tx, ja_in_rx, ja_bw_low, tx_powered_down;
	logic [1:0] tx_driver_hiz, tx_data_invert, tx_sample_rising;
	logic [1:0] tx_hdb3_en, tx_ami_en, tx_dual_rail;
	int num_errors = 0;
	int num_checks = 0;
	line_unit_cfg_regs line_unit_cfg_regs_i (
		.core_clk(core_clk), .sys_rst(sys_rst), .cs_n(cs_n),
		.wr_n(wr_n), .rd_n(rd_n), .addr(addr), .d_in(d_in),
		.d_out(d_out), .d_oe(d_oe), .chan_irq_pending(chan_irq_pending),
		.irq_out(irq_out), .irq_oe(irq_oe), .mon_rx_path(mon_rx_path),
		.mon_tx_path(mon_tx_path), .tx_term_sel(tx_term_sel),
		.rx_term_sel(rx_term_sel), .attenuator_limit_mode(attenuator_limit_mode),
		.ja_in_tx(ja_in_tx), .ja_in_rx(ja_in_rx),
		.ja_depth_sel(ja_depth_sel), .ja_bw_low(ja_bw_low),
		.tx_powered_down(tx_powered_down),
		.tx_driver_hiz(tx_driver_hiz), .tx_data_invert(tx_data_invert),
		.tx_sample_rising(tx_sample_rising), .tx_hdb3_en(tx_hdb3_en),
		.tx_ami_en(tx_ami_en), .tx_dual_rail(tx_dual_rail));
	host_bus_model host_bus_model_i (
		.core_clk(core_clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
		.addr(addr), .d_in(d_in), .d_out(d_out), .d_oe(d_oe));
	// 250 MHz clock
	initial forever #2 core_clk = ~core_clk;
	// Compare and count
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		num_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// Register read and compare
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] s;
		host_bus_model_i.rd(a, s);
		chk($sformatf("register %h", a), e, s);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_bus_model_i.wr(a, d);
	endtask
	task automatic summarize();
		$display("Checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("reset pins", 8'h3f,
			{2'h0, tx_hdb3_en, attenuator_limit_mode, tx_driver_hiz});
		rchk(8'h00, 8'ha5);
		rchk(8'h20, 8'h04);
		rchk(8'h03, 8'h20);
		rchk(8'h01, 8'h00);
		rchk(8'h10, 8'h00);
		wr(8'h00, 8'h5a);
		rchk(8'h00, 8'ha5);
		wr(8'h02, 8'h21);
		wr(8'h22, 8'h08);
		chk("termination", 8'h61, {tx_term_sel, rx_term_sel});
		rchk(8'h22, 8'h08);
		wr(8'h03, 8'h1b);
		chk("attenuator", 8'h34, {attenuator_limit_mode[0], ja_in_tx[0], ja_in_rx[0],
			ja_bw_low[0], ja_depth_sel[1:0], 2'b00});
		wr(8'h03, 8'h0c);
		chk("attenuator", 8'h48, {attenuator_limit_mode[0], ja_in_tx[0], ja_in_rx[0],
			ja_bw_low[0], ja_depth_sel[1:0], 2'b00});
		// Every coding mode with polarity and edge
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h04, {3'b000, 1'b0, i[0], i[1], i[1:0]});
			chk("transmit", {3'b000, i[0], i[1], i == 0, i == 1, i[1]},
				{2'b00, tx_driver_hiz[0], tx_data_invert[0], tx_sample_rising[0],
				tx_hdb3_en[0], tx_ami_en[0], tx_dual_rail[0]});
		end
		wr(8'h04, 8'h10);
		chk("power down", 8'h03, {6'h00, tx_driver_hiz[0], tx_powered_down[0]});
		// Broadcast copies a channel two write
		wr(8'h20, 8'h08);
		wr(8'h23, 8'h18);
		chk("broadcast", 8'h03, {6'h00, ja_in_rx});
		rchk(8'h03, 8'h18);
		for (int m = 0; m < 4; m++)
		begin
			wr(8'h20, {m[1:0], 6'h00});
			chk("monitor", {6'h00, m == 3, m == 1}, {6'h00, mon_tx_path, mon_rx_path});
		end
		// Interrupt pin in every style
		chan_irq_pending <= 2'b01;
		for (int s = 0; s < 4; s++)
		begin
			wr(8'h20, {6'h00, s[1:0]});
			chk("irq active", {6'h00, 1'b1, s == 3}, {6'h00, irq_oe, irq_out});
			chan_irq_pending <= 2'b00;
			repeat (3) @(posedge core_clk);
			chk("irq idle", {6'h00, s[0], s == 1}, {6'h00, irq_oe, irq_out});
			chan_irq_pending <= 2'b01;
			repeat (3) @(posedge core_clk);
		end
		wr(8'h20, 8'h04);
		chk("irq masked", 8'h00, {6'h00, irq_oe, irq_out});
		chan_irq_pending <= 2'b10;
		rchk(8'h21, 8'h01);
		// Channel two driver on, so the soft reset has work to do
		wr(8'h24, 8'h00);
		chk("driver on", 8'h01, {6'h00, tx_driver_hiz});
		// Soft reset restores defaults
		wr(8'h01, 8'h00);
		chk("soft reset", 8'h0f, {4'h0, attenuator_limit_mode, tx_driver_hiz});
		rchk(8'h03, 8'h20);
		rchk(8'h22, 8'h00);
		summarize();
	end
endmodule // tb
`default_nettype wire
